// >>> common/rmsq_pkg.sv
package rmsq_pkg;
    localparam int unsigned CLK_HZ        = 20_000_000;
    localparam int unsigned TICK_CYC      = CLK_HZ / 1000;
    localparam int unsigned DEBOUNCE_MS   = 60;
    localparam int unsigned CONVERT_MS    = 200;
    localparam int unsigned MIN_CLOSE_MS  = 260;
    localparam int unsigned MIN_OPEN_MS   = 60;
    localparam int unsigned TICK_W        = 15;
    localparam int unsigned MS_W          = 20;
    localparam logic [9:0]  TIME_OFF      = 10'h000;
    localparam int unsigned SEC_MS        = 1000;

    typedef enum logic [1:0] {
        RMSQ_IDLE,
        RMSQ_CHARGE,
        RMSQ_MEASURE
    } rmsq_state_t;
endpackage

// >>> hdl/rmsq_sequencer.sv
// Operation
// - Close starts charging or measurement, open ends it.
// - Level change valid after 60 ms stable.
// - Result only after 200 ms conversion.
// - Measuring timer ends measurement automatically.
// - Valid opening ends measurement before timer.
// - Charging timer then measurement; opening aborts.
// - Charge, measure, timed end; opening terminates.
`timescale 1ns/1ps
`default_nettype none
module rmsq_sequencer
    import rmsq_pkg::*;
#(
    // Clock frequency that the millisecond tick is derived from.
    parameter int unsigned CLK_FREQ_HZ = CLK_HZ
)
(
    input  wire logic       ref_clk,
    input  wire logic       reset,
    input  wire logic       remote_closed,
    input  wire logic [9:0] charge_time_s,
    input  wire logic [9:0] measure_time_s,
    output logic            charging,
    output logic            measuring,
    output logic            result_valid,
    output logic            meas_done
);
    typedef struct packed {
        logic              sync1;
        logic              sync2;
        logic              level;
        logic [TICK_W-1:0] tick_cnt;
        logic              tick;
        logic [6:0]        deb_ms;
        rmsq_state_t       state;
        logic [MS_W-1:0]   phase_ms;
        logic [7:0]        conv_ms;
        logic              charging;
        logic              measuring;
        logic              result_valid;
        logic              meas_done;
    } rmsq_regs_t;

    rmsq_regs_t r_reg;
    rmsq_regs_t r_next;

    assign charging     = r_reg.charging;
    assign measuring    = r_reg.measuring;
    assign result_valid = r_reg.result_valid;
    assign meas_done    = r_reg.meas_done;

    localparam int unsigned       TICK_N    = CLK_FREQ_HZ / 1000;
    localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_N - 1);
    localparam logic [6:0]        DEB_LAST  = 7'(DEBOUNCE_MS);
    localparam logic [7:0]        CONV_LAST = 8'(CONVERT_MS);

    logic [MS_W-1:0] charge_ms;
    logic [MS_W-1:0] measure_ms;
    assign charge_ms  = MS_W'(charge_time_s * SEC_MS);
    assign measure_ms = MS_W'(measure_time_s * SEC_MS);

    always_comb begin
        logic open_ev;
        logic close_ev;
        open_ev  = 1'b0;
        close_ev = 1'b0;
        r_next = r_reg;
        r_next.sync1 = remote_closed;
        r_next.sync2 = r_reg.sync1;
        r_next.meas_done = 1'b0;
        // Free-running millisecond tick from the system clock.
        r_next.tick = (r_reg.tick_cnt == TICK_LAST);
        r_next.tick_cnt = r_next.tick ? '0 : r_reg.tick_cnt + 1'b1;
        // A differing level must hold for the full debounce span.
        if (r_reg.sync2 == r_reg.level) begin
            r_next.deb_ms = '0;
        end else if (r_reg.tick) begin
            if (r_reg.deb_ms == DEB_LAST - 7'h01) begin
                r_next.level  = r_reg.sync2;
                r_next.deb_ms = '0;
                close_ev = r_reg.sync2;
                open_ev  = ~r_reg.sync2;
            end else begin
                r_next.deb_ms = r_reg.deb_ms + 7'h01;
            end
        end
        unique case (r_reg.state)
            RMSQ_IDLE: begin
                if (close_ev) begin
                    r_next.phase_ms     = '0;
                    r_next.conv_ms      = '0;
                    r_next.result_valid = 1'b0;
                    if (charge_time_s != TIME_OFF) begin
                        r_next.state    = RMSQ_CHARGE;
                        r_next.charging = 1'b1;
                    end else begin
                        r_next.state     = RMSQ_MEASURE;
                        r_next.measuring = 1'b1;
                    end
                end
            end
            RMSQ_CHARGE: begin
                if (open_ev) begin
                    r_next.state    = RMSQ_IDLE;
                    r_next.charging = 1'b0;
                end else if (r_reg.tick) begin
                    if (r_reg.phase_ms >= charge_ms - 1'b1) begin
                        r_next.state     = RMSQ_MEASURE;
                        r_next.charging  = 1'b0;
                        r_next.measuring = 1'b1;
                        r_next.phase_ms  = '0;
                    end else begin
                        r_next.phase_ms = r_reg.phase_ms + 1'b1;
                    end
                end
            end
            RMSQ_MEASURE: begin
                if (r_reg.tick && r_reg.conv_ms != CONV_LAST) begin
                    r_next.conv_ms = r_reg.conv_ms + 8'h01;
                end
                // Conversion must finish before any result appears.
                if (r_reg.conv_ms == CONV_LAST) begin
                    r_next.result_valid = 1'b1;
                end
                if (r_reg.tick) begin
                    r_next.phase_ms = r_reg.phase_ms + 1'b1;
                end
                if (open_ev) begin
                    r_next.state     = RMSQ_IDLE;
                    r_next.measuring = 1'b0;
                    r_next.meas_done = 1'b1;
                end else if (measure_time_s != TIME_OFF && r_reg.tick
                             && r_reg.phase_ms >= measure_ms - 1'b1) begin
                    r_next.state     = RMSQ_IDLE;
                    r_next.measuring = 1'b0;
                    r_next.meas_done = 1'b1;
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    sequence s_meas_start;
        !r_reg.measuring ##1 r_reg.measuring;
    endsequence

    // An accepted opening: the debounced level drops.
    sequence s_level_open;
        $fell(r_reg.level);
    endsequence

    // An accepted closing: the debounced level rises.
    sequence s_level_close;
        $rose(r_reg.level);
    endsequence

    // A completed conversion: the counter has reached its last value.
    sequence s_conv_full;
        $past(r_reg.conv_ms) == CONV_LAST;
    endsequence

    a_result_after_conv: assert property (@(posedge ref_clk) disable iff (reset)
        s_meas_start |-> !r_reg.result_valid [*8])
        else $error("Result issued before conversion finished.");

    a_tick_period: assert property (@(posedge ref_clk) disable iff (reset)
        r_reg.tick |-> (r_reg.tick_cnt == '0) ##1 !r_reg.tick)
        else $error("Millisecond tick period broken.");

    a_level_stable: assert property (@(posedge ref_clk) disable iff (reset)
        $changed(r_reg.level) |-> $past(r_reg.deb_ms) == DEB_LAST - 7'h01)
        else $error("Level accepted before debounce span.");

    a_open_ends_meas: assert property (@(posedge ref_clk) disable iff (reset)
        $past(r_reg.measuring) && s_level_open |-> !r_reg.measuring && r_reg.meas_done)
        else $error("Valid opening did not end measurement.");

    a_open_aborts_chg: assert property (@(posedge ref_clk) disable iff (reset)
        $past(r_reg.charging) && s_level_open |-> !r_reg.charging && !r_reg.measuring)
        else $error("Valid opening did not abort charging.");

    a_close_starts: assert property (@(posedge ref_clk) disable iff (reset)
        ($past(r_reg.state) == RMSQ_IDLE) && s_level_close |->
            (r_reg.charging || r_reg.measuring))
        else $error("Closing did not start sequence.");

    a_timer_end: assert property (@(posedge ref_clk) disable iff (reset)
        (r_reg.measuring && measure_time_s != TIME_OFF && r_reg.tick
         && r_reg.phase_ms >= measure_ms - 1'b1) |=> !r_reg.measuring)
        else $error("Measuring timer did not end measurement.");

    a_chg_to_meas: assert property (@(posedge ref_clk) disable iff (reset)
        $fell(r_reg.charging) && r_reg.level |-> r_reg.measuring)
        else $error("Charging expiry did not start measurement.");

    // The result may only rise once the conversion counter is full.
    a_result_gate: assert property (@(posedge ref_clk) disable iff (reset)
        $rose(r_reg.result_valid) |-> s_conv_full)
        else $error("Result rose without a full conversion.");

    a_done_pulse: assert property (@(posedge ref_clk) disable iff (reset)
        r_reg.meas_done |=> !r_reg.meas_done)
        else $error("End pulse lasted more than one cycle.");

    a_open_stops_all: assert property (@(posedge ref_clk) disable iff (reset)
        s_level_open |-> !r_reg.charging && !r_reg.measuring)
        else $error("Valid opening left the sequence running.");

    a_idle_quiet: assert property (@(posedge ref_clk) disable iff (reset)
        (r_reg.state == RMSQ_IDLE) |-> !r_reg.charging && !r_reg.measuring)
        else $error("Outputs active while idle.");
endmodule
`default_nettype wire

// >>> testbench/rmsq_remote_switch.sv
`timescale 1ns/1ps
`default_nettype none
module rmsq_remote_switch
    import rmsq_pkg::*;
#(
    parameter int unsigned CLK_FREQ_HZ = CLK_HZ
)
(
    input  wire logic ref_clk,
    output var logic  remote_closed
);
    initial begin
        remote_closed = 1'b0;
    end

    // Sets the contact level just after an edge and keeps it for whole milliseconds.
    task automatic hold(input logic level, input int unsigned ms);
        @(posedge ref_clk);
        #1;
        remote_closed = level;
        repeat (ms * (CLK_FREQ_HZ / 1000) - 1) @(posedge ref_clk);
    endtask
endmodule
`default_nettype wire

// >>> testbench/rmsq_sequencer_tb.sv
`timescale 1ns/1ps
`default_nettype none
module rmsq_sequencer_tb;
    import rmsq_pkg::*;
    // Scaled clock figure so that one millisecond is 20 cycles in simulation.
    localparam int unsigned SIM_CLK_HZ = 20_000;
    logic       ref_clk        = 1'b0;
    logic       reset          = 1'b1;
    logic [9:0] charge_time_s  = TIME_OFF;
    logic [9:0] measure_time_s = TIME_OFF;
    logic       remote_closed;
    logic       charging;
    logic       measuring;
    logic       result_valid;
    logic       meas_done;
    int         errors         = 0;
    int         comparisons    = 0;
    int         done_cnt       = 0;

    always #25 ref_clk = ~ref_clk;

    always @(posedge ref_clk) begin
        if (meas_done === 1'b1) begin
            done_cnt <= done_cnt + 1;
        end
    end

    rmsq_remote_switch #(
        .CLK_FREQ_HZ (SIM_CLK_HZ)
    ) rmsq_remote_switch_inst (
        .ref_clk       (ref_clk),
        .remote_closed (remote_closed)
    );

    rmsq_sequencer #(
        .CLK_FREQ_HZ (SIM_CLK_HZ)
    ) rmsq_sequencer_inst (
        .ref_clk        (ref_clk),
        .reset          (reset),
        .remote_closed  (remote_closed),
        .charge_time_s  (charge_time_s),
        .measure_time_s (measure_time_s),
        .charging       (charging),
        .measuring      (measuring),
        .result_valid   (result_valid),
        .meas_done      (meas_done)
    );

    task automatic check(input logic [31:0] seen, input logic [31:0] expected, input string what);
        comparisons++;
        if (seen !== expected) begin
            errors++;
            $display("unexpected at %0t: %s", $time, what);
        end
    endtask

    task automatic final_report();
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic test_chatter();
        int d;
        d = done_cnt;
        rmsq_remote_switch_inst.hold(1'b1, 30);
        rmsq_remote_switch_inst.hold(1'b0, 100);
        check(measuring, 1'b0, "short closure started a measurement");
        check(32'(done_cnt - d), 32'h0, "short closure ended a measurement");
    endtask

    task automatic test_full();
        int d;
        d = done_cnt;
        rmsq_remote_switch_inst.hold(1'b1, 70);
        check(measuring, 1'b1, "closure did not start measuring");
        check(charging, 1'b0, "charging without charge time");
        rmsq_remote_switch_inst.hold(1'b0, 30);
        rmsq_remote_switch_inst.hold(1'b1, 40);
        check(measuring, 1'b1, "short opening stopped measuring");
        check(result_valid, 1'b0, "result before conversion time");
        rmsq_remote_switch_inst.hold(1'b1, 200);
        check(result_valid, 1'b1, "no result after conversion time");
        rmsq_remote_switch_inst.hold(1'b0, 70);
        check(measuring, 1'b0, "opening did not stop measuring");
        check(32'(done_cnt - d), 32'h1, "end pulse count after opening");
        check(result_valid, 1'b1, "result dropped before next start");
    endtask

    task automatic test_short();
        int d;
        d = done_cnt;
        rmsq_remote_switch_inst.hold(1'b1, 150);
        check(measuring, 1'b1, "closure did not start measuring");
        rmsq_remote_switch_inst.hold(1'b0, 70);
        check(result_valid, 1'b0, "result from too short a closure");
        check(32'(done_cnt - d), 32'h1, "end pulse count after short closure");
    endtask

    task automatic test_charge_abort();
        charge_time_s = 10'h001;
        rmsq_remote_switch_inst.hold(1'b1, 70);
        check(charging, 1'b1, "closure did not start charging");
        check(measuring, 1'b0, "measuring during charge time");
        rmsq_remote_switch_inst.hold(1'b0, 70);
        check(charging, 1'b0, "opening did not abort charging");
        check(measuring, 1'b0, "measuring after aborted charge");
        charge_time_s = TIME_OFF;
    endtask

    task automatic test_timers();
        int d;
        d = done_cnt;
        charge_time_s  = 10'h001;
        measure_time_s = 10'h001;
        rmsq_remote_switch_inst.hold(1'b1, 70);
        check(charging, 1'b1, "closure did not start charging");
        rmsq_remote_switch_inst.hold(1'b1, 1000);
        check(measuring, 1'b1, "charge expiry did not start measuring");
        check(charging, 1'b0, "charging after charge expiry");
        rmsq_remote_switch_inst.hold(1'b1, 1000);
        check(measuring, 1'b0, "measuring timer did not end measuring");
        check(32'(done_cnt - d), 32'h1, "end pulse count after timer");
        check(result_valid, 1'b1, "no result after timed measurement");
        rmsq_remote_switch_inst.hold(1'b0, 70);
        check(32'(done_cnt - d), 32'h1, "opening after timer ended again");
        charge_time_s  = TIME_OFF;
        measure_time_s = TIME_OFF;
    endtask

    task automatic test_open_early();
        int d;
        d = done_cnt;
        measure_time_s = 10'h001;
        rmsq_remote_switch_inst.hold(1'b1, 270);
        check(measuring, 1'b1, "closure did not start timed measuring");
        rmsq_remote_switch_inst.hold(1'b0, 70);
        check(measuring, 1'b0, "opening did not beat the timer");
        check(32'(done_cnt - d), 32'h1, "end pulse count after early open");
        measure_time_s = TIME_OFF;
    endtask

    initial begin
        #5_000_000;
        errors++;
        final_report();
    end

    initial begin
        repeat (3) @(posedge ref_clk);
        #1;
        reset = 1'b0;
        test_chatter();
        test_full();
        test_short();
        test_charge_abort();
        test_timers();
        test_open_early();
        final_report();
    end
endmodule
`default_nettype wire
